// ==== verilog/fwd_table.sv ====
/*
 Station address forwarding table: lookup, learning, ageing, static
 entries, filtering and sorted read-out.
 Assumes the receive pipeline presents one frame per request pulse and
 management drives commands on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module fwd_table
   import fwd_table_pkg::*;
#(
   parameter int DEPTH        = TABLE_DEPTH,
   parameter int TICK_CYCLES  = CYCLES_PER_S
) (
   input  wire logic                  clk,          // System clock
   input  wire logic                  arst_n,       // Async reset, active low
   input  wire logic                  frm_valid,    // Frame request pulse
   input  wire logic [ADDR_W-1:0]     dest_station_addr, // Destination address
   input  wire logic [ADDR_W-1:0]     src_station_addr,  // Source address
   input  wire logic [VLAN_W-1:0]     frm_vlan,     // Frame VLAN
   input  wire logic [PORT_IDX_W-1:0] frm_port,     // Arrival port
   input  wire logic [NUM_PORTS-1:0]  vlan_ports,   // Member ports of frame VLAN
   output logic                       fwd_valid,    // Decision pulse
   output logic [NUM_PORTS-1:0]       fwd_ports,    // Egress port mask
   output logic                       fwd_drop,     // Frame discarded
   output logic                       fwd_flood,    // Destination unknown
   input  wire logic                  mgmt_valid,   // Command pulse
   input  wire fwd_table_pkg::mgmt_op_e mgmt_op,    // Command
   input  wire logic [ADDR_W-1:0]     mgmt_addr,    // Command address
   input  wire logic [VLAN_W-1:0]     mgmt_vlan,    // Command VLAN
   input  wire logic [PORT_IDX_W-1:0] mgmt_port,    // Static egress port
   input  wire logic                  age_wr,       // Write ageing interval
   input  wire logic [AGE_W-1:0]      age_wr_s,     // New interval, seconds
   output logic [AGE_W-1:0]           age_s,        // Current interval
   input  wire logic                  flt_wr,       // Write filter slot
   input  wire logic [1:0]            flt_slot,     // Filter slot
   input  wire logic                  flt_en,       // Filter slot valid
   input  wire logic                  dump_start,   // Start read-out
   output logic                       dump_valid,   // Entry pulse
   output logic                       dump_done,    // Read-out finished pulse
   output logic [ADDR_W-1:0]          dump_addr,    // Entry address
   output logic [VLAN_W-1:0]          dump_vlan,    // Entry VLAN
   output logic                       dump_static,  // Entry is static
   output logic [NUM_PORTS-1:0]       dump_ports,   // Entry member ports
   output logic                       busy          // Dump in progress
);
   // ==========================================================
   // Table storage
   logic [DEPTH-1:0]     val_reg,  val_next;
   logic [DEPTH-1:0]     stat_reg, stat_next;
   logic [ADDR_W-1:0]    adr_reg  [DEPTH];
   logic [ADDR_W-1:0]    adr_next [DEPTH];
   logic [VLAN_W-1:0]    vln_reg  [DEPTH];
   logic [VLAN_W-1:0]    vln_next [DEPTH];
   logic [NUM_PORTS-1:0] prt_reg  [DEPTH];
   logic [NUM_PORTS-1:0] prt_next [DEPTH];
   logic [AGE_W-1:0]     idle_reg [DEPTH];
   logic [AGE_W-1:0]     idle_next[DEPTH];

   logic tick;
   logic flt_hit;

   sec_tick #(.CYCLES(TICK_CYCLES)) u_tick (
      .clk    (clk),
      .arst_n (arst_n),
      .tick   (tick)
   );

   filter_list #(.DEPTH(FILTER_DEPTH)) u_flt (
      .clk      (clk),
      .arst_n   (arst_n),
      .wr_en    (flt_wr),
      .wr_slot  (flt_slot),
      .wr_valid (flt_en),
      .wr_addr  (mgmt_addr),
      .wr_vlan  (mgmt_vlan),
      .q_addr   (dest_station_addr),
      .q_vlan   (frm_vlan),
      .hit      (flt_hit)
   );

   // ==========================================================
   // Match vectors
   logic [DEPTH-1:0] d_hit, s_hit, m_hit;
   logic [DEPTH-1:0] free_v, dyn_v;
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_match
         assign d_hit[g]  = val_reg[g] && adr_reg[g] == dest_station_addr
                            && vln_reg[g] == frm_vlan;
         assign s_hit[g]  = val_reg[g] && adr_reg[g] == src_station_addr
                            && vln_reg[g] == frm_vlan;
         assign m_hit[g]  = val_reg[g] && adr_reg[g] == mgmt_addr
                            && vln_reg[g] == mgmt_vlan;
         assign free_v[g] = !val_reg[g];
         assign dyn_v[g]  = val_reg[g] && !stat_reg[g];
      end
   endgenerate

   function automatic logic [IDX_W-1:0] first_idx(input logic [DEPTH-1:0] v);
      first_idx = '0;
      for (int i = DEPTH - 1; i >= 0; i--) begin
         if (v[i]) first_idx = IDX_W'(i);
      end
   endfunction

   function automatic logic [NUM_PORTS-1:0] or_ports(input logic [DEPTH-1:0] v,
                                                     input logic [NUM_PORTS-1:0] p [DEPTH]);
      or_ports = '0;
      for (int i = 0; i < DEPTH; i++) begin
         if (v[i]) or_ports = or_ports | p[i];
      end
   endfunction

   // ==========================================================
   // Forwarding decision
   logic                 fwd_valid_next, fwd_drop_next, fwd_flood_next;
   logic [NUM_PORTS-1:0] fwd_ports_next;
   logic [NUM_PORTS-1:0] arr_mask;

   always_comb begin
      arr_mask       = NUM_PORTS'(1) << frm_port;
      fwd_valid_next = frm_valid;
      fwd_drop_next  = frm_valid && flt_hit;
      fwd_flood_next = frm_valid && !flt_hit && d_hit == '0;
      if (!frm_valid || flt_hit) begin
         fwd_ports_next = '0;
      end else if (d_hit != '0) begin
         fwd_ports_next = or_ports(d_hit, prt_reg) & ~arr_mask;
      end else begin
         fwd_ports_next = vlan_ports & ~arr_mask;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fwd_valid <= 1'b0;
         fwd_ports <= '0;
         fwd_drop  <= 1'b0;
         fwd_flood <= 1'b0;
      end else begin
         fwd_valid <= fwd_valid_next;
         fwd_ports <= fwd_ports_next;
         fwd_drop  <= fwd_drop_next;
         fwd_flood <= fwd_flood_next;
      end
   end

   // ==========================================================
   // Ageing interval
   logic [AGE_W-1:0] age_next;

   always_comb begin
      age_next = age_s;
      if (age_wr) begin
         if (age_wr_s < AGE_MIN_S) age_next = AGE_MIN_S;
         else if (age_wr_s > AGE_MAX_S) age_next = AGE_MAX_S;
         else age_next = age_wr_s;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) age_s <= AGE_DEFAULT_S;
      else age_s <= age_next;
   end

   // ==========================================================
   // Entry maintenance: learning, ageing, management
   logic [IDX_W-1:0] learn_idx, mgmt_idx;
   logic             learn_ok;

   always_comb begin
      val_next  = val_reg;
      stat_next = stat_reg;
      for (int i = 0; i < DEPTH; i++) begin
         adr_next[i]  = adr_reg[i];
         vln_next[i]  = vln_reg[i];
         prt_next[i]  = prt_reg[i];
         idle_next[i] = idle_reg[i];
         if (tick && dyn_v[i]) begin
            if (idle_reg[i] >= age_s) val_next[i] = 1'b0;
            else idle_next[i] = idle_reg[i] + AGE_W'(1);
         end
      end
      learn_ok  = frm_valid && !flt_hit && frm_vlan >= VLAN_MIN;
      learn_idx = first_idx(s_hit != '0 ? s_hit : free_v != '0 ? free_v : dyn_v);
      if (learn_ok && !(s_hit != '0 && stat_reg[learn_idx])
          && (s_hit != '0 || free_v != '0 || dyn_v != '0)) begin
         val_next[learn_idx]  = 1'b1;
         stat_next[learn_idx] = 1'b0;
         adr_next[learn_idx]  = src_station_addr;
         vln_next[learn_idx]  = frm_vlan;
         prt_next[learn_idx]  = NUM_PORTS'(1) << frm_port;
         idle_next[learn_idx] = '0;
      end
      mgmt_idx = first_idx(m_hit != '0 ? m_hit : free_v);
      if (mgmt_valid) begin
         unique case (mgmt_op)
            MGMT_ADD_STAT: begin
               if (m_hit != '0 || free_v != '0) begin
                  val_next[mgmt_idx]  = 1'b1;
                  stat_next[mgmt_idx] = 1'b1;
                  adr_next[mgmt_idx]  = mgmt_addr;
                  vln_next[mgmt_idx]  = mgmt_vlan;
                  prt_next[mgmt_idx]  = NUM_PORTS'(1) << mgmt_port;
               end
            end
            MGMT_DEL_STAT: begin
               if (m_hit != '0) val_next[mgmt_idx] = 1'b0;
            end
            MGMT_PROMOTE: begin
               if (m_hit != '0) stat_next[mgmt_idx] = 1'b1;
            end
            MGMT_NONE: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         val_reg  <= '0;
         stat_reg <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            adr_reg[i]  <= '0;
            vln_reg[i]  <= '0;
            prt_reg[i]  <= '0;
            idle_reg[i] <= '0;
         end
      end else begin
         val_reg  <= val_next;
         stat_reg <= stat_next;
         for (int i = 0; i < DEPTH; i++) begin
            adr_reg[i]  <= adr_next[i];
            vln_reg[i]  <= vln_next[i];
            prt_reg[i]  <= prt_next[i];
            idle_reg[i] <= idle_next[i];
         end
      end
   end

   // ==========================================================
   // Sorted read-out: each step emits the smallest key above the last one
   localparam int KEY_W = VLAN_W + ADDR_W;
   logic [KEY_W-1:0] last_reg, last_next;
   logic             first_reg, first_next;
   logic             busy_next, dv_next, dd_next;
   logic [KEY_W-1:0] best_key;
   logic [IDX_W-1:0] best_idx;
   logic             found;
   logic [KEY_W-1:0] k;
   logic [ADDR_W-1:0]    da_next;
   logic [VLAN_W-1:0]    dvl_next;
   logic                 ds_next;
   logic [NUM_PORTS-1:0] dp_next;

   always_comb begin
      best_key = '1;
      best_idx = '0;
      found    = 1'b0;
      k        = '0;
      for (int i = 0; i < DEPTH; i++) begin
         k = {vln_reg[i], adr_reg[i]};
         if (val_reg[i] && (first_reg || k > last_reg) && (!found || k < best_key)) begin
            best_key = k;
            best_idx = IDX_W'(i);
            found    = 1'b1;
         end
      end
      busy_next  = busy;
      last_next  = last_reg;
      first_next = first_reg;
      dv_next    = 1'b0;
      dd_next    = 1'b0;
      da_next    = dump_addr;
      dvl_next   = dump_vlan;
      ds_next    = dump_static;
      dp_next    = dump_ports;
      if (!busy) begin
         if (dump_start) begin
            busy_next  = 1'b1;
            first_next = 1'b1;
         end
      end else if (found) begin
         dv_next    = 1'b1;
         da_next    = adr_reg[best_idx];
         dvl_next   = vln_reg[best_idx];
         ds_next    = stat_reg[best_idx];
         dp_next    = prt_reg[best_idx];
         last_next  = best_key;
         first_next = 1'b0;
      end else begin
         busy_next = 1'b0;
         dd_next   = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy        <= 1'b0;
         last_reg    <= '0;
         first_reg   <= 1'b0;
         dump_valid  <= 1'b0;
         dump_done   <= 1'b0;
         dump_addr   <= '0;
         dump_vlan   <= '0;
         dump_static <= 1'b0;
         dump_ports  <= '0;
      end else begin
         busy        <= busy_next;
         last_reg    <= last_next;
         first_reg   <= first_next;
         dump_valid  <= dv_next;
         dump_done   <= dd_next;
         dump_addr   <= da_next;
         dump_vlan   <= dvl_next;
         dump_static <= ds_next;
         dump_ports  <= dp_next;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/fwd_table_pkg.sv ====
/*
 Constants and types for the station address forwarding table.
 Assumes a single 100 MHz system clock.
*/
package fwd_table_pkg;
   localparam int ADDR_W          = 48;
   localparam int VLAN_W          = 13;
   localparam int NUM_PORTS       = 8;
   localparam int PORT_IDX_W      = 3;
   localparam int TABLE_DEPTH     = 16;
   localparam int IDX_W           = 4;
   localparam int FILTER_DEPTH    = 4;
   localparam int AGE_W           = 10;
   localparam logic [AGE_W-1:0] AGE_MIN_S     = 10'h00a;
   localparam logic [AGE_W-1:0] AGE_MAX_S     = 10'h276;
   localparam logic [AGE_W-1:0] AGE_DEFAULT_S = 10'h12c;
   localparam logic [VLAN_W-1:0] VLAN_MIN     = 13'h0001;
   localparam logic [VLAN_W-1:0] VLAN_MAX     = 13'h1000;
   localparam int CLK_HZ          = 100000000;
   localparam int SECOND_NS       = 1000000000;
   localparam int CLK_PERIOD_NS   = 10;
   localparam int CYCLES_PER_S    = SECOND_NS / CLK_PERIOD_NS;
   localparam int ENTRY_W         = ADDR_W + VLAN_W + NUM_PORTS + AGE_W + 2;

   typedef enum logic [1:0] {
      MGMT_NONE     = 2'b00,
      MGMT_ADD_STAT = 2'b01,
      MGMT_DEL_STAT = 2'b10,
      MGMT_PROMOTE  = 2'b11
   } mgmt_op_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_LEARN = 2'b01,
      ST_DUMP  = 2'b10
   } ctl_state_e;
endpackage

// ==== verilog/sec_tick.sv ====
/*
 One-second tick generator.
 Assumes the system clock rate given in the package.
*/
`timescale 1ns/1ns
`default_nettype none
module sec_tick
   import fwd_table_pkg::*;
#(
   parameter int CYCLES = CYCLES_PER_S
) (
   input  wire logic clk,    // System clock
   input  wire logic arst_n, // Async reset, active low
   output logic      tick    // One-cycle pulse each second
);
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic        tick_next;

   always_comb begin
      tick_next = (cnt_reg == 32'(CYCLES - 1));
      cnt_next  = tick_next ? 32'h0 : cnt_reg + 32'h1;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 32'h0;
         tick    <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick    <= tick_next;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/filter_list.sv ====
/*
 Filter list of station address and VLAN pairs, matched in one cycle.
 Assumes writes come from management logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module filter_list
   import fwd_table_pkg::*;
#(
   parameter int DEPTH = FILTER_DEPTH
) (
   input  wire logic              clk,     // System clock
   input  wire logic              arst_n,  // Async reset, active low
   input  wire logic              wr_en,   // Write slot
   input  wire logic [1:0]        wr_slot, // Slot index
   input  wire logic              wr_valid,// Slot valid to store
   input  wire logic [ADDR_W-1:0] wr_addr, // Address to store
   input  wire logic [VLAN_W-1:0] wr_vlan, // VLAN to store
   input  wire logic [ADDR_W-1:0] q_addr,  // Address to match
   input  wire logic [VLAN_W-1:0] q_vlan,  // VLAN to match
   output logic                   hit      // Pair is listed
);
   logic [DEPTH-1:0]  val_reg;
   logic [DEPTH-1:0]  val_next;
   logic [ADDR_W-1:0] adr_reg  [DEPTH];
   logic [ADDR_W-1:0] adr_next [DEPTH];
   logic [VLAN_W-1:0] vln_reg  [DEPTH];
   logic [VLAN_W-1:0] vln_next [DEPTH];
   logic [DEPTH-1:0]  m;
   logic [DEPTH-1:0]  sel;
   logic              wr_ok;

   // A slot only becomes live for a VLAN inside the legal range
   assign wr_ok = wr_valid && wr_vlan >= VLAN_MIN && wr_vlan <= VLAN_MAX;

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_slot
         assign m[g]   = val_reg[g] && adr_reg[g] == q_addr && vln_reg[g] == q_vlan;
         assign sel[g] = wr_en && wr_slot == 2'(g);
         always_comb begin
            val_next[g] = sel[g] ? wr_ok : val_reg[g];
            adr_next[g] = sel[g] ? wr_addr : adr_reg[g];
            vln_next[g] = sel[g] ? wr_vlan : vln_reg[g];
         end
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               val_reg[g] <= 1'b0;
               adr_reg[g] <= '0;
               vln_reg[g] <= '0;
            end else begin
               val_reg[g] <= val_next[g];
               adr_reg[g] <= adr_next[g];
               vln_reg[g] <= vln_next[g];
            end
         end
      end
   endgenerate

   assign hit = |m;
endmodule
`default_nettype wire

// ==== sim/fwd_table_asserts.sv ====
/*
 Checker for the forwarding table top ports.
 Assumes a bind onto fwd_table, one clock and an async active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module fwd_table_asserts
   import fwd_table_pkg::*;
(
   input wire logic                  clk,        // Clock
   input wire logic                  arst_n,     // Reset
   input wire logic                  frm_valid,  // Frame pulse
   input wire logic [PORT_IDX_W-1:0] frm_port,   // Arrival port
   input wire logic [NUM_PORTS-1:0]  vlan_ports, // VLAN members
   input wire logic                  fwd_valid,  // Decision pulse
   input wire logic [NUM_PORTS-1:0]  fwd_ports,  // Egress mask
   input wire logic                  fwd_drop,   // Discarded
   input wire logic                  fwd_flood,  // Miss
   input wire logic                  age_wr,     // Interval write
   input wire logic [AGE_W-1:0]      age_wr_s,   // New interval
   input wire logic [AGE_W-1:0]      age_s,      // Interval
   input wire logic                  dump_start, // Read-out start
   input wire logic                  dump_valid, // Entry pulse
   input wire logic                  dump_done,  // Read-out end
   input wire logic                  busy        // Read-out running
);
   // ============================================================
   // Helpers
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   function automatic logic [AGE_W-1:0] clamp(input logic [AGE_W-1:0] s);
      return (s < AGE_MIN_S) ? AGE_MIN_S : ((s > AGE_MAX_S) ? AGE_MAX_S : s);
   endfunction

   sequence s_start;
      dump_start && !busy;
   endsequence

   sequence s_end;
      dump_done && !busy && !dump_valid;
   endsequence

   // ============================================================
   // Frame path
   a_fwd_answer: assert property (frm_valid |=> fwd_valid)
      else $error("no decision one cycle after a frame");
   a_fwd_quiet: assert property (!frm_valid |=> !fwd_valid)
      else $error("decision without a frame");
   a_no_return: assert property (fwd_valid |-> !fwd_ports[$past(frm_port)])
      else $error("frame sent back to its arrival port");
   a_flood_mask: assert property (fwd_flood |-> fwd_valid &&
      fwd_ports == ($past(vlan_ports) & ~(NUM_PORTS'(1) << $past(frm_port))))
      else $error("flood mask wrong");
   a_drop_empty: assert property (fwd_drop |-> fwd_valid && fwd_ports == '0)
      else $error("dropped frame has egress ports");

   // ============================================================
   // Ageing interval
   a_age_range: assert property (age_s >= AGE_MIN_S && age_s <= AGE_MAX_S)
      else $error("ageing interval out of range");
   a_age_write: assert property (age_wr |=> age_s == clamp($past(age_wr_s)))
      else $error("ageing interval write not taken");
   a_age_hold: assert property (!age_wr |=> $stable(age_s))
      else $error("ageing interval changed without write");

   // ============================================================
   // Read-out
   a_dump_busy: assert property (s_start |=> busy)
      else $error("read-out did not start");
   a_dump_bound: assert property (s_start |-> ##[2:18] s_end)
      else $error("read-out did not finish");
   a_entry_busy: assert property (dump_valid |-> busy)
      else $error("entry outside read-out");
endmodule

bind fwd_table fwd_table_asserts u_chk (
   .clk, .arst_n, .frm_valid, .frm_port, .vlan_ports, .fwd_valid, .fwd_ports,
   .fwd_drop, .fwd_flood, .age_wr, .age_wr_s, .age_s, .dump_start,
   .dump_valid, .dump_done, .busy
);
`default_nettype wire

// ==== sim/rx_pipe_model.sv ====
/*
 Model of the frame receive pipeline feeding the table.
 Assumes the caller runs on the same clock; frames go out at the falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module rx_pipe_model
   import fwd_table_pkg::*;
(
   input  wire logic                  clk,               // System clock
   output logic                       frm_valid,         // Frame pulse
   output logic [ADDR_W-1:0]          dest_station_addr, // Destination
   output logic [ADDR_W-1:0]          src_station_addr,  // Source
   output logic [VLAN_W-1:0]          frm_vlan,          // VLAN
   output logic [PORT_IDX_W-1:0]      frm_port,          // Arrival port
   output logic [NUM_PORTS-1:0]       vlan_ports         // VLAN members
);
   // ============================================================
   // Frame issue
   initial begin
      frm_valid = 1'b0;
      dest_station_addr = '0;
      src_station_addr = '0;
      frm_vlan = '0;
      frm_port = '0;
      vlan_ports = '0;
   end

   task automatic send(input logic [ADDR_W-1:0] d, s, input logic [VLAN_W-1:0] v,
         input logic [PORT_IDX_W-1:0] p, input logic [NUM_PORTS-1:0] m);
      @(negedge clk);
      frm_valid = 1'b1;
      dest_station_addr = d;
      src_station_addr = s;
      frm_vlan = v;
      frm_port = p;
      vlan_ports = m;
      @(negedge clk);
      frm_valid = 1'b0;
      // Idle lines carry junk so stale frame data is never reused
      dest_station_addr = ~d;
      src_station_addr = ~s;
      frm_vlan = ~v;
      frm_port = ~p;
      vlan_ports = ~m;
   endtask
endmodule
`default_nettype wire

// ==== sim/fwd_table_tb_top.sv ====
/*
 Self-checking testbench for the forwarding table.
 Assumes the receive pipeline model and a short one-second tick.
*/
`timescale 1ns/1ns
`default_nettype none
module fwd_table_tb_top
   import fwd_table_pkg::*;
;
   // ============================================================
   // Signals
   localparam logic [ADDR_W-1:0] STA_A = 48'h0000000000a1;
   localparam logic [ADDR_W-1:0] STA_B = 48'h0100000000b0;
   localparam logic [ADDR_W-1:0] STA_C = 48'h00000000c0c0;
   localparam logic [ADDR_W-1:0] STA_D = 48'h0200000000d0;
   localparam logic [ADDR_W-1:0] STA_E = 48'h0000000000e1;
   localparam logic [ADDR_W-1:0] STA_F = 48'h000000000050;
   localparam logic [ADDR_W-1:0] STA_X = 48'h0abc00000099;
   logic                  clk, arst_n, frm_valid, fwd_valid, fwd_drop, fwd_flood;
   logic [ADDR_W-1:0]     dest_station_addr, src_station_addr, mgmt_addr, dump_addr;
   logic [VLAN_W-1:0]     frm_vlan, mgmt_vlan, dump_vlan;
   logic [PORT_IDX_W-1:0] frm_port, mgmt_port;
   logic [NUM_PORTS-1:0]  vlan_ports, fwd_ports, dump_ports;
   logic                  mgmt_valid, age_wr, flt_wr, flt_en, dump_start;
   logic                  dump_valid, dump_done, dump_static, busy;
   logic [AGE_W-1:0]      age_wr_s, age_s;
   logic [1:0]            flt_slot;
   mgmt_op_e              mgmt_op;
   int                    num_errors = 0;
   int                    n_compared = 0;

   fwd_table #(.TICK_CYCLES(10)) dut (
      .clk, .arst_n, .frm_valid, .dest_station_addr, .src_station_addr, .frm_vlan,
      .frm_port, .vlan_ports, .fwd_valid, .fwd_ports, .fwd_drop, .fwd_flood,
      .mgmt_valid, .mgmt_op, .mgmt_addr, .mgmt_vlan, .mgmt_port, .age_wr, .age_wr_s,
      .age_s, .flt_wr, .flt_slot, .flt_en, .dump_start, .dump_valid, .dump_done,
      .dump_addr, .dump_vlan, .dump_static, .dump_ports, .busy
   );

   rx_pipe_model u_rx (
      .clk, .frm_valid, .dest_station_addr, .src_station_addr, .frm_vlan,
      .frm_port, .vlan_ports
   );

   // ============================================================
   // Shared tasks
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize;
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic frame(input logic [ADDR_W-1:0] d, s, input logic [VLAN_W-1:0] v,
         input logic [PORT_IDX_W-1:0] p, input logic [NUM_PORTS-1:0] m, e, input logic f);
      u_rx.send(d, s, v, p, m);
      chk({fwd_valid, fwd_drop, fwd_flood, fwd_ports}, {1'b1, 1'b0, f, e});
   endtask

   task automatic mgmt(input mgmt_op_e op, input logic [ADDR_W-1:0] a,
         input logic [VLAN_W-1:0] v, input logic [PORT_IDX_W-1:0] p);
      @(negedge clk);
      mgmt_valid = 1'b1;
      mgmt_op = op;
      mgmt_addr = a;
      mgmt_vlan = v;
      mgmt_port = p;
      @(negedge clk);
      mgmt_valid = 1'b0;
   endtask

   task automatic age(input logic [AGE_W-1:0] s, e);
      @(negedge clk);
      age_wr = 1'b1;
      age_wr_s = s;
      @(negedge clk);
      age_wr = 1'b0;
      chk(age_s, e);
   endtask

   // ============================================================
   // Scenarios
   task automatic t_learn;
      frame(STA_X, STA_A, 13'h0005, 3'h1, 8'hff, 8'hfd, 1'b1);
      frame(STA_A, STA_E, 13'h0005, 3'h2, 8'hff, 8'h02, 1'b0);
   endtask

   task automatic t_static;
      mgmt(MGMT_ADD_STAT, STA_B, 13'h0005, 3'h4);
      mgmt(MGMT_ADD_STAT, STA_F, 13'h0005, 3'h5);
      frame(STA_X, STA_B, 13'h0005, 3'h6, 8'hff, 8'hbf, 1'b1);
      frame(STA_B, STA_E, 13'h0005, 3'h0, 8'hff, 8'h10, 1'b0);
      mgmt(MGMT_ADD_STAT, STA_C, 13'h0007, 3'h2);
      frame(STA_C, STA_E, 13'h0007, 3'h0, 8'h0f, 8'h04, 1'b0);
      mgmt(MGMT_DEL_STAT, STA_C, 13'h0007, 3'h0);
      frame(STA_C, STA_E, 13'h0007, 3'h0, 8'h0f, 8'h0e, 1'b1);
   endtask

   task automatic t_promote;
      frame(STA_X, STA_D, 13'h0003, 3'h3, 8'h0f, 8'h07, 1'b1);
      mgmt(MGMT_PROMOTE, STA_D, 13'h0003, 3'h0);
      frame(STA_D, STA_E, 13'h0003, 3'h1, 8'h0f, 8'h08, 1'b0);
   endtask

   task automatic t_filter;
      @(negedge clk);
      flt_wr = 1'b1;
      flt_slot = 2'h0;
      flt_en = 1'b1;
      mgmt_addr = STA_C;
      mgmt_vlan = 13'h0005;
      @(negedge clk);
      flt_wr = 1'b0;
      u_rx.send(STA_C, STA_B, 13'h0005, 3'h4, 8'hff);
      chk({fwd_valid, fwd_drop, fwd_flood, fwd_ports}, {1'b1, 1'b1, 1'b0, 8'h00});
      frame(STA_C, STA_B, 13'h0006, 3'h4, 8'hff, 8'hef, 1'b1);
   endtask

   task automatic t_ageing;
      age(10'h005, AGE_MIN_S);
      age(10'h2bc, AGE_MAX_S);
      age(10'h00a, 10'h00a);
      repeat (150) @(negedge clk);
      frame(STA_A, STA_B, 13'h0005, 3'h4, 8'hff, 8'hef, 1'b1);
      frame(STA_D, STA_B, 13'h0003, 3'h4, 8'h1f, 8'h08, 1'b0);
      frame(STA_B, STA_A, 13'h0005, 3'h0, 8'hff, 8'h10, 1'b0);
   endtask

   task automatic t_dump;
      logic [71:0] got [8];
      logic [71:0] ex [5];
      int n;
      n = 0;
      ex = '{{STA_B, 13'h0003, 1'b0, 8'h10}, {STA_D, 13'h0003, 1'b1, 8'h08},
             {STA_F, 13'h0005, 1'b1, 8'h20}, {STA_A, 13'h0005, 1'b0, 8'h01},
             {STA_B, 13'h0005, 1'b1, 8'h10}};
      @(negedge clk);
      dump_start = 1'b1;
      @(negedge clk);
      dump_start = 1'b0;
      chk(busy, 1'b1);
      for (int i = 0; i < 20 && dump_done !== 1'b1; i++) begin
         @(negedge clk);
         if (dump_valid === 1'b1 && n < 8) begin
            got[n] = {dump_addr, dump_vlan, dump_static, dump_ports};
            n++;
         end
      end
      chk(n, 5);
      chk({dump_done, busy}, 2'b10);
      for (int i = 0; i < 5; i++) begin
         chk(got[i], ex[i]);
      end
   endtask

   // ============================================================
   // Clock, reset, sequence and watchdog
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      summarize();
   end

   initial begin
      arst_n = 1'b0;
      {mgmt_valid, age_wr, flt_wr, flt_en, dump_start} = '0;
      mgmt_op = MGMT_NONE;
      {mgmt_addr, mgmt_vlan, mgmt_port, age_wr_s, flt_slot} = '0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      chk({age_s, fwd_valid, busy}, {AGE_DEFAULT_S, 2'b00});
      t_learn();
      t_static();
      t_promote();
      t_filter();
      t_ageing();
      t_dump();
      summarize();
   end
endmodule
`default_nettype wire
